//--- core/rlo_regs.sv
// Relay output board register bank with bus slave and address decoder
// Operation
// - Control/status bits 15..13 act; all sixteen bits read back.
// - Fail indicator lit while control/status bit 15 is zero.
// - Reset clears control/status bit 15, lighting the fail indicator.
// - Bit 14 enables channels 1-32 drivers; bit 13 channels 33-64.
// - Disabled half drives no coils; relays fall to unenergised position.
// - Reset clears both driver-enable bits.
// - Command bit one energises that relay's set coil when enabled.
// - Command bit zero energises the reset coil when enabled.
// - Contact sense bits report auxiliary contacts, lagging up to 5.5 ms.
// - Command registers read back the last written value.
// - Every register is accessible at any time, test mode included.
// - Each half enters test mode independently of the other.
// - Short addressing ignores A23-A16; standard includes them.
// - Privilege jumpers select nonprivileged, either, or supervisory modifiers.
// - Installed base jumper requires address low; uninstalled requires high.
// - Selected cycle writes or reads the addressed register, then acknowledges.
// - Acknowledge four clocks (160 ns, 150 ns rounded up) after select; rearm when both strobes high.
// - Read data held until both data strobes return high.
// - Writes to read-only words are acknowledged and discarded.
module rlo_regs (
   input  wire logic                 CLK_I,
   input  wire logic                 RESET_I,
   input  wire rlo_pkg::rlo_bus_s    VME_I,
   input  wire rlo_pkg::rlo_jumper_s JUMPER_I,
   input  wire logic [63:0]          CONTACT_SENSE_I,
   output logic [15:0]               D_O,
   output logic                      D_OE_O,
   output logic                      DTACK_N_O,
   output logic                      DTACK_OE_O,
   output logic                      FAIL_LED_O,
   output logic                      LOWER_DRV_EN_O,
   output logic                      UPPER_DRV_EN_O,
   output logic [63:0]               SET_COIL_O,
   output logic [63:0]               RESET_COIL_O
);
   import rlo_pkg::*;

   rlo_state_s s_q;
   rlo_state_s s_d;
   logic       select;
   logic       strobes_idle;
   logic       en_lo;
   logic       en_hi;
   logic [63:0] en_mask;

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   function automatic logic addr_match(input logic [23:1] a,
                                       input rlo_jumper_s j);
      logic ok;
      ok = 1'b1;
      for (int i = RLO_BASE_LSB; i <= RLO_ADDR_HI; i++) begin
         if (j.std_addr || i < RLO_STD_FIRST) begin
            if (a[i] == j.base_select_header[i-RLO_BASE_LSB]) begin
               ok = 1'b0;
            end
         end
      end
      return ok;
   endfunction

   function automatic logic am_match(input logic [5:0] am,
                                     input rlo_jumper_s j);
      logic np;
      logic sv;
      np = j.std_addr ? (am == RLO_AM_STD_NP) : (am == RLO_AM_SHORT_NP);
      sv = j.std_addr ? (am == RLO_AM_STD_SV) : (am == RLO_AM_SHORT_SV);
      if (j.am_either) begin
         return np || sv;
      end else if (j.am_nonpriv) begin
         return np;
      end else begin
         return sv;
      end
   endfunction

   function automatic logic [15:0] read_word(input logic [3:0]  w,
                                             input logic [15:0] control_status,
                                             input logic [63:0] cmd,
                                             input logic [63:0] sense);
      int base;
      base = (RLO_GRP_WORDS - 1 - int'(w[1:0])) * RLO_WORD_BITS;
      if (w == RLO_WORD_CSR) begin
         return control_status;
      end else if (w[3:2] == RLO_GRP_CMD) begin
         return cmd[base +: RLO_WORD_BITS];
      end else if (w[3:2] == RLO_GRP_SENSE) begin
         return sense[base +: RLO_WORD_BITS];
      end else begin
         return RLO_WORD_ZERO;
      end
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   assign select = !VME_I.as_n && !(VME_I.ds0_n && VME_I.ds1_n)
                   && addr_match(VME_I.addr, JUMPER_I)
                   && am_match(VME_I.am, JUMPER_I);
   assign strobes_idle = VME_I.ds0_n && VME_I.ds1_n;

   always_comb begin
      int base;
      s_d  = s_q;
      base = (RLO_GRP_WORDS - 1 - int'(s_q.word[1:0])) * RLO_WORD_BITS;
      unique case (s_q.fsm)
         RLO_IDLE: begin
            if (select) begin
               s_d.fsm     = RLO_WAIT;
               s_d.cnt     = RLO_CNT_ZERO;
               s_d.word    = VME_I.addr[4:1];
               s_d.wr      = !VME_I.write_n;
               s_d.lane_hi = !VME_I.ds1_n;
               s_d.lane_lo = !VME_I.ds0_n;
               s_d.wdata   = VME_I.data;
            end
         end
         RLO_WAIT: begin
            s_d.cnt = s_q.cnt + RLO_CNT_ONE;
            if (s_q.cnt == RLO_DTACK_LAST) begin
               s_d.fsm     = RLO_ACK;
               s_d.dtack_n = 1'b0;
               s_d.dtack_oe = 1'b1;
               s_d.d_oe    = !s_q.wr;
               s_d.rdata   = read_word(s_q.word, s_q.control_status_word,
                                       s_q.relay_command, CONTACT_SENSE_I);
               if (s_q.wr && s_q.word == RLO_WORD_CSR) begin
                  if (s_q.lane_hi) begin
                     s_d.control_status_word[15:8] = s_q.wdata[15:8];
                  end
                  if (s_q.lane_lo) begin
                     s_d.control_status_word[7:0] = s_q.wdata[7:0];
                  end
               end
               // Sense words and unused words drop write data
               if (s_q.wr && s_q.word[3:2] == RLO_GRP_CMD) begin
                  if (s_q.lane_hi) begin
                     s_d.relay_command[base+8 +: 8] = s_q.wdata[15:8];
                  end
                  if (s_q.lane_lo) begin
                     s_d.relay_command[base +: 8] = s_q.wdata[7:0];
                  end
               end
            end
         end
         RLO_ACK: begin
            if (strobes_idle) begin
               s_d.fsm     = RLO_IDLE;
               s_d.dtack_n = 1'b1;
               s_d.dtack_oe = 1'b0;
               s_d.d_oe    = 1'b0;
            end
         end
         default: begin
            s_d.fsm     = RLO_IDLE;
            s_d.dtack_n = 1'b1;
            s_d.dtack_oe = 1'b0;
            s_d.d_oe    = 1'b0;
         end
      endcase
      // Coil drive from the next-cycle register contents
      en_lo   = s_d.control_status_word[RLO_CSR_EN_LOW];
      en_hi   = s_d.control_status_word[RLO_CSR_EN_HIGH];
      en_mask = {{32{en_hi}}, {32{en_lo}}};
      s_d.set_coil   = s_d.relay_command & en_mask;
      s_d.reset_coil = ~s_d.relay_command & en_mask;
      s_d.fail_led   = !s_d.control_status_word[RLO_CSR_LED];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         s_q                     <= '0;
         s_q.fsm                 <= RLO_IDLE;
         s_q.dtack_n             <= 1'b1;
         s_q.fail_led            <= 1'b1;
         s_q.control_status_word <= RLO_CSR_RESET;
         s_q.relay_command       <= RLO_CMD_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign D_O            = s_q.rdata;
   assign D_OE_O         = s_q.d_oe;
   assign DTACK_N_O      = s_q.dtack_n;
   assign DTACK_OE_O     = s_q.dtack_oe;
   assign FAIL_LED_O     = s_q.fail_led;
   assign LOWER_DRV_EN_O = s_q.control_status_word[RLO_CSR_EN_LOW];
   assign UPPER_DRV_EN_O = s_q.control_status_word[RLO_CSR_EN_HIGH];
   assign SET_COIL_O     = s_q.set_coil;
   assign RESET_COIL_O   = s_q.reset_coil;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   dtack_delay_a: assert property (
      (s_q.fsm == RLO_IDLE && select) |=> DTACK_N_O [*4] ##1 !DTACK_N_O)
      else $error("acknowledge not four cycles after select");

   dtack_release_a: assert property (
      (!DTACK_N_O && !strobes_idle) |=> !DTACK_N_O)
      else $error("acknowledge dropped before strobes released");

   rearm_idle_a: assert property (
      (!DTACK_N_O && strobes_idle) |=> DTACK_N_O && s_q.fsm == RLO_IDLE)
      else $error("select logic not rearmed after strobes released");

   read_hold_a: assert property (
      (D_OE_O && !strobes_idle) |=> D_OE_O && $stable(D_O))
      else $error("read data not held while strobes low");

   led_follow_a: assert property (
      FAIL_LED_O == !s_q.control_status_word[RLO_CSR_LED])
      else $error("fail indicator does not follow control bit");

   reset_clear_a: assert property (
      @(posedge CLK_I) disable iff (1'b0)
      $past(RESET_I) |-> FAIL_LED_O && !LOWER_DRV_EN_O && !UPPER_DRV_EN_O)
      else $error("reset did not clear control bits");

   lower_gate_a: assert property (
      !LOWER_DRV_EN_O |-> (SET_COIL_O[31:0] | RESET_COIL_O[31:0]) == '0)
      else $error("lower half coils driven while disabled");

   upper_gate_a: assert property (
      !UPPER_DRV_EN_O |-> (SET_COIL_O[63:32] | RESET_COIL_O[63:32]) == '0)
      else $error("upper half coils driven while disabled");

   coil_follow_a: assert property (
      (LOWER_DRV_EN_O && UPPER_DRV_EN_O) |->
         SET_COIL_O == s_q.relay_command
         && RESET_COIL_O == ~s_q.relay_command)
      else $error("coils do not follow command while enabled");

   sense_discard_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.wr && s_q.word[3:2] == RLO_GRP_SENSE)
      |=> $stable(s_q.relay_command) && $stable(s_q.control_status_word))
      else $error("write to read-only word changed state");

   cmd_readback_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.cnt == RLO_DTACK_LAST && !s_q.wr
       && s_q.word[3:2] == RLO_GRP_CMD && s_q.word[1:0] == 2'h0)
      |=> D_O == s_q.relay_command[63:48])
      else $error("command word read-back mismatch");

   no_select_a: assert property (
      (s_q.fsm == RLO_IDLE && !select) |=> s_q.fsm == RLO_IDLE)
      else $error("cycle answered without a decoder match");

   dtack_pair_a: assert property (
      DTACK_OE_O == !DTACK_N_O)
      else $error("acknowledge enable disagrees with its level");

   read_drive_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.cnt == RLO_DTACK_LAST && !s_q.wr)
      |=> D_OE_O && !DTACK_N_O)
      else $error("read data not driven with acknowledge");

   write_quiet_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.wr) |=> !D_OE_O)
      else $error("data bus driven on a write cycle");

   csr_store_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.cnt == RLO_DTACK_LAST && s_q.wr
       && s_q.word == RLO_WORD_CSR && s_q.lane_hi && s_q.lane_lo)
      |=> s_q.control_status_word == s_q.wdata)
      else $error("control word not stored as written");

   cmd_store_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.cnt == RLO_DTACK_LAST && s_q.wr
       && s_q.word[3:2] == RLO_GRP_CMD && s_q.word[1:0] == 2'h0
       && s_q.lane_hi && s_q.lane_lo)
      |=> s_q.relay_command[63:48] == s_q.wdata)
      else $error("command word not stored as written");

   idle_quiet_a: assert property (
      s_q.fsm != RLO_ACK |-> DTACK_N_O && !D_OE_O)
      else $error("bus driven outside the acknowledge phase");

   lane_keep_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.cnt == RLO_DTACK_LAST && s_q.wr
       && s_q.word[3:2] == RLO_GRP_CMD && s_q.word[1:0] == 2'h0
       && !s_q.lane_hi)
      |=> $stable(s_q.relay_command[63:56]))
      else $error("unselected byte lane of command word changed");

   wait_count_a: assert property (
      s_q.fsm == RLO_WAIT |-> s_q.cnt <= RLO_DTACK_LAST)
      else $error("acknowledge counter ran past its end");

   sense_read_a: assert property (
      (s_q.fsm == RLO_WAIT && s_q.cnt == RLO_DTACK_LAST && !s_q.wr
       && s_q.word[3:2] == RLO_GRP_SENSE && s_q.word[1:0] == 2'h0)
      |=> D_O == $past(CONTACT_SENSE_I[63:48]))
      else $error("contact sense word read-back mismatch");

endmodule // rlo_regs

//--- pkg/rlo_pkg.sv
// Package: constants and carrier types for the relay output register bank
package rlo_pkg;

   // ----------------------------------------------------------------
   // Register words, addressed by A4..A1 inside the board window
   // ----------------------------------------------------------------
   localparam logic [3:0]  RLO_WORD_CSR    = 4'h1;
   localparam logic [1:0]  RLO_GRP_CMD     = 2'h2;
   localparam logic [1:0]  RLO_GRP_SENSE   = 2'h3;
   localparam int          RLO_WORD_BITS   = 16;
   localparam int          RLO_GRP_WORDS   = 4;

   // ----------------------------------------------------------------
   // Control/status word fields
   // ----------------------------------------------------------------
   localparam int          RLO_CSR_LED     = 15;
   localparam int          RLO_CSR_EN_LOW  = 14;
   localparam int          RLO_CSR_EN_HIGH = 13;
   localparam logic [15:0] RLO_CSR_RESET   = 16'h0000;
   localparam logic [15:0] RLO_WORD_ZERO   = 16'h0000;
   localparam logic [63:0] RLO_CMD_RESET   = 64'h0000_0000_0000_0000;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   localparam int          RLO_ADDR_HI     = 23;
   localparam int          RLO_BASE_LSB    = 5;
   localparam int          RLO_BASE_W      = RLO_ADDR_HI - RLO_BASE_LSB + 1;
   localparam int          RLO_STD_FIRST   = 16;
   localparam logic [5:0]  RLO_AM_SHORT_NP = 6'h29;
   localparam logic [5:0]  RLO_AM_SHORT_SV = 6'h2D;
   localparam logic [5:0]  RLO_AM_STD_NP   = 6'h39;
   localparam logic [5:0]  RLO_AM_STD_SV   = 6'h3D;

   // ----------------------------------------------------------------
   // Acknowledge timing
   // ----------------------------------------------------------------
   localparam int          RLO_CLK_NS      = 40;
   localparam int          RLO_DTACK_NS    = 150;
   localparam int          RLO_DTACK_CYC   =
      (RLO_DTACK_NS + RLO_CLK_NS - 1) / RLO_CLK_NS;
   localparam logic [2:0]  RLO_DTACK_LAST  = 3'(RLO_DTACK_CYC - 1);
   localparam logic [2:0]  RLO_CNT_ZERO    = 3'h0;
   localparam logic [2:0]  RLO_CNT_ONE     = 3'h1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RLO_IDLE = 2'b00,
      RLO_WAIT = 2'b01,
      RLO_ACK  = 2'b10
   } rlo_fsm_e;

   typedef struct packed {
      logic [23:1] addr;
      logic [5:0]  am;
      logic        as_n;
      logic        ds1_n;
      logic        ds0_n;
      logic        write_n;
      logic [15:0] data;
   } rlo_bus_s;

   typedef struct packed {
      logic [RLO_BASE_W-1:0] base_select_header;
      logic                  std_addr;
      logic                  am_nonpriv;
      logic                  am_either;
   } rlo_jumper_s;

   typedef struct packed {
      rlo_fsm_e    fsm;
      logic [2:0]  cnt;
      logic [3:0]  word;
      logic        wr;
      logic        lane_hi;
      logic        lane_lo;
      logic [15:0] wdata;
      logic [15:0] control_status_word;
      logic [63:0] relay_command;
      logic [15:0] rdata;
      logic        dtack_n;
      logic        dtack_oe;
      logic        fail_led;
      logic        d_oe;
      logic [63:0] set_coil;
      logic [63:0] reset_coil;
   } rlo_state_s;

endpackage

//--- verif/rlo_host.sv
// Host processor model issuing single transfer cycles to the board
module rlo_host (
   input  wire logic         clk_i,
   input  wire logic         dtack_n_i,
   input  wire logic [15:0]  d_i,
   output rlo_pkg::rlo_bus_s vme_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import rlo_pkg::*;

   initial begin
      vme_o = '0;
      vme_o.as_n = 1'b1;
      {vme_o.ds1_n, vme_o.ds0_n} = 2'b11;
      vme_o.write_n = 1'b1;
   end

   task automatic xfer(input logic [23:1] a, input logic [5:0] am,
      input logic wr, input logic [15:0] wd, input logic [1:0] ds_n,
      output logic [15:0] rd, output int lat, output int rel);
      int n;
      n = 0;
      lat = -1;
      @(negedge clk_i);
      vme_o.addr = a;
      vme_o.am = am;
      vme_o.write_n = ~wr;
      vme_o.data = wr ? wd : ~vme_o.data;
      vme_o.as_n = 1'b0;
      {vme_o.ds1_n, vme_o.ds0_n} = ds_n;
      while (lat < 0 && n < 12) begin
         @(negedge clk_i);
         n++;
         if (dtack_n_i === 1'b0) lat = n;
      end
      rd = d_i;
      // Hold strobes through the edge that samples the acknowledge
      @(posedge clk_i);
      @(negedge clk_i);
      vme_o.as_n = 1'b1;
      {vme_o.ds1_n, vme_o.ds0_n} = 2'b11;
      // Released lines must not keep the last value
      vme_o.addr = ~a;
      vme_o.data = ~vme_o.data;
      rel = 0;
      do begin
         @(negedge clk_i);
         rel++;
      end while (dtack_n_i !== 1'b1 && rel < 4);
   endtask
endmodule // rlo_host

//--- verif/bus_relay_output_registers_test.sv
// Self-checking bench for the relay output register bank
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %0t got %h expected %h", $time, g, e); end end
module bus_relay_output_registers_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rlo_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   rlo_bus_s    vme;
   rlo_jumper_s jmp;
   logic [63:0] sense, set_c, rst_c, m_cmd;
   logic [15:0] d, rd, m_csr, wv;
   logic [15:0] lf = 16'hDA18;
   logic        d_oe, dtack_n, dtack_oe, led, lo_en, up_en, ok;
   int          err_count, checks_done, lat, rel;

   always #20 clk = ~clk;

   rlo_regs u_dut (.CLK_I(clk), .RESET_I(rst), .VME_I(vme), .JUMPER_I(jmp),
      .CONTACT_SENSE_I(sense), .D_O(d), .D_OE_O(d_oe), .DTACK_N_O(dtack_n),
      .DTACK_OE_O(dtack_oe), .FAIL_LED_O(led), .LOWER_DRV_EN_O(lo_en),
      .UPPER_DRV_EN_O(up_en), .SET_COIL_O(set_c), .RESET_COIL_O(rst_c));
   rlo_host u_host (.clk_i(clk), .dtack_n_i(dtack_n), .d_i(d), .vme_o(vme));

   function automatic logic [15:0] nx();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   function automatic logic [23:1] adr(input logic [3:0] w);
      return {~jmp.base_select_header, w};
   endfunction

   task automatic acc(input logic [3:0] w, input logic wr,
      input logic [15:0] wd, input logic [1:0] ds_n = 2'b00);
      u_host.xfer(adr(w), RLO_AM_SHORT_SV, wr, wd, ds_n, rd, lat, rel);
      `CHK(lat, RLO_DTACK_CYC + 1)
      `CHK(rel, 1)
      `CHK({d_oe, dtack_oe}, 2'b00)
   endtask

   task automatic outs();
      logic [63:0] en;
      en = {{32{m_csr[13]}}, {32{m_csr[14]}}};
      `CHK(led, ~m_csr[15])
      `CHK({lo_en, up_en}, m_csr[14:13])
      `CHK(set_c, m_cmd & en)
      `CHK(rst_c, ~m_cmd & en)
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #(40 * 10000);
      err_count++;
      tally_and_finish();
   end

   initial begin
      jmp = '0;
      jmp.am_either = 1'b1;
      jmp.base_select_header = {nx(), 3'h5};
      sense = '0;
      m_csr = RLO_CSR_RESET;
      m_cmd = RLO_CMD_RESET;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      outs();
      acc(RLO_WORD_CSR, 1'b0, 16'h0000);
      `CHK(rd, RLO_CSR_RESET)
      for (int e = 0; e < 4; e++) begin
         m_csr = nx();
         m_csr[14:13] = 2'(e);
         acc(RLO_WORD_CSR, 1'b1, m_csr);
         acc(RLO_WORD_CSR, 1'b0, 16'h0000);
         `CHK(rd, m_csr)
         for (int w = 8; w < 12; w++) begin
            m_cmd[16 * (11 - w) +: 16] = nx();
            acc(4'(w), 1'b1, m_cmd[16 * (11 - w) +: 16]);
         end
         outs();
         for (int w = 8; w < 12; w++) begin
            acc(4'(w), 1'b0, 16'h0000);
            `CHK(rd, m_cmd[16 * (11 - w) +: 16])
         end
         // Contacts taken as settled after the host's wait
         sense = {nx(), nx(), nx(), nx()};
         for (int w = 12; w < 16; w++) begin
            acc(4'(w), 1'b1, nx());
            acc(4'(w), 1'b0, 16'h0000);
            `CHK(rd, sense[16 * (15 - w) +: 16])
         end
         acc(4'h0, 1'b1, nx());
         acc(4'h0, 1'b0, 16'h0000);
         `CHK(rd, RLO_WORD_ZERO)
         outs();
      end
      // Single byte lanes into command word 8
      for (int b = 0; b < 2; b++) begin
         wv = nx();
         m_cmd[48 + 8 * b +: 8] = wv[8 * b +: 8];
         acc(4'h8, 1'b1, wv, b[0] ? 2'b01 : 2'b10);
         acc(4'h8, 1'b0, 16'h0000);
         `CHK(rd, m_cmd[48 +: 16])
      end
      outs();
      // Jumper modes against modifiers and address variants
      for (int s = 0; s < 2; s++)
         for (int m = 0; m < 3; m++)
            for (int a = 0; a < 4; a++)
               for (int v = 0; v < 3; v++) begin
                  logic [5:0]  am;
                  logic [23:1] ad;
                  am = a[1] ? (a[0] ? RLO_AM_STD_SV : RLO_AM_STD_NP)
                            : (a[0] ? RLO_AM_SHORT_SV : RLO_AM_SHORT_NP);
                  jmp.std_addr = s[0];
                  jmp.am_nonpriv = (m == 0);
                  jmp.am_either = (m == 1);
                  ad = adr(RLO_WORD_CSR);
                  if (v == 1) ad[23:16] = ~ad[23:16];
                  if (v == 2) ad[5] = ~ad[5];
                  ok = (a[1] == s[0]) && (m == 1 || (m == 0) == (a[0] == 0))
                       && (v == 0 || (v == 1 && s == 0));
                  u_host.xfer(ad, am, 1'b0, 16'h0000, 2'b00, rd, lat, rel);
                  `CHK(lat, ok ? RLO_DTACK_CYC + 1 : -1)
               end
      jmp.std_addr = 1'b0;
      jmp.am_nonpriv = 1'b0;
      jmp.am_either = 1'b1;
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      m_csr = RLO_CSR_RESET;
      m_cmd = RLO_CMD_RESET;
      outs();
      acc(4'h8, 1'b0, 16'h0000);
      `CHK(rd, RLO_WORD_ZERO)
      tally_and_finish();
   end
endmodule // bus_relay_output_registers_test
